/* File: core/mpr_ctl_end.sv */
// controller end: register port and pattern-register sequencer
`timescale 1ns/10ps
`include "mpr_defines.svh"
module mpr_ctl_end
  import mpr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        dll_locked,
  mpr_link_if.ctl          link
);
  ctl_reg_t           q_reg;
  ctl_reg_t           q_next;
  op_t                op;
  logic [1:0]         sel;
  logic [`ADDR_W-1:0] val;
  logic [2:0]         lim;
  logic               cmd_wr;
  logic               refuse;
  logic               inc;
  logic               dec;
  logic               rd_set;
  logic               ref_set;

  // decode of a command word
  assign op     = op_t'(reg_wdata[`CMD_OP_LSB +: 3]);
  assign sel    = reg_wdata[`CMD_SEL_LSB +: 2];
  assign val    = reg_wdata[`CMD_VAL_LSB +: `ADDR_W];
  assign cmd_wr = reg_wr && reg_addr == `REG_CMD;
  assign lim    = (q_reg.bl == `BL_FIX4) ? 3'h3 : 3'h7;

  // refusals keep the dram out of illegal sequences
  always_comb begin
    refuse = q_reg.st != C_IDLE || op == OP_NONE;
    if (op == OP_ENTER && q_reg.on) begin
      refuse = 1'b1;
    end
    if ((op == OP_READ || op == OP_ROT || op == OP_WRITE ||
         op == OP_EXIT) && !q_reg.on) begin
      refuse = 1'b1;
    end
    if (op == OP_WRITE && q_reg.mpage != 2'h0) begin
      refuse = 1'b1;
    end
  end

  // next state of the whole controller
  always_comb begin
    q_next      = q_reg;
    q_next.cmd  = CMD_DES;
    q_next.ba   = 2'h0;
    q_next.bg   = 2'h0;
    q_next.addr = '0;
    inc         = 1'b0;
    dec         = 1'b0;
    rd_set      = 1'b0;
    ref_set     = 1'b0;

    // configuration and flag clears; sets below win
    if (reg_wr && reg_addr == `REG_CFG) begin
      q_next.page   = reg_wdata[`CFG_PAGE_LSB +: 2];
      q_next.fmt    = reg_wdata[`CFG_FMT_LSB +: 2];
      q_next.bl     = reg_wdata[`CFG_BL_LSB +: 2];
      q_next.dll_en = reg_wdata[`CFG_DLL_BIT];
    end
    if (reg_wr && reg_addr == `REG_STAT) begin
      if (reg_wdata[`ST_REF]) begin
        q_next.refused = 1'b0;
      end
      if (reg_wdata[`ST_RDONE]) begin
        q_next.rdone = 1'b0;
      end
    end

    // capture of lanes 0 to 3, one byte per lane
    if (link.dq_valid) begin
      for (int k = 0; k < 4; k++) begin
        q_next.cap[k * 8 + int'(q_reg.bcnt)] = link.dq[k];
      end
      q_next.bcnt = q_reg.bcnt + 3'h1;
      if (q_reg.bcnt == lim) begin
        q_next.rword = q_next.cap;
        q_next.bcnt  = 3'h0;
        dec          = 1'b1;
        rd_set       = 1'b1;
      end
    end

    unique case (q_reg.st)
      C_IDLE: begin
        if (cmd_wr && refuse) begin
          ref_set = 1'b1;
        end else if (cmd_wr) begin
          q_next.ret = C_IDLE;
          unique case (op)
            OP_NONE: ;
            OP_ENTER: q_next.st = C_DLL;
            OP_READ: begin
              q_next.loc = sel;
              q_next.rot = 2'h0;
              q_next.st  = C_RD;
            end
            OP_ROT: begin
              q_next.loc = sel;
              q_next.rot = 2'h3;
              q_next.st  = C_RD;
            end
            OP_WRITE: begin
              // data rides on the address pins, dq stays idle
              q_next.cmd       = CMD_WR;
              q_next.ba        = sel;
              q_next.bg        = {1'b0, reg_wdata[`CMD_BG_BIT]};
              q_next.addr[7:0] = val[7:0];
              q_next.tmr       = 8'(`T_WR_MPR_CK);
              q_next.st        = C_WAIT;
            end
            OP_EXIT: q_next.st = C_DRAIN;
            OP_REF: begin
              // plain 1x refresh; no finer mode is ever issued
              q_next.cmd = CMD_REF;
              q_next.tmr = 8'(`T_RFC_CK);
              q_next.st  = C_WAIT;
            end
            OP_MRS: begin
              q_next.cmd  = CMD_MRS;
              q_next.ba   = sel;
              q_next.bg   = {1'b0, reg_wdata[`CMD_BG_BIT]};
              q_next.addr = val;
              q_next.tmr  = 8'(`T_MOD_CK);
              q_next.st   = C_WAIT;
            end
          endcase
        end
      end
      C_DLL: begin
        // wait for lock unless dll_en is clear, then precharge all and hold tRP
        if (!q_reg.dll_en || dll_locked) begin
          q_next.cmd = CMD_PREA;
          q_next.tmr = 8'(`T_RP_CK);
          q_next.ret = C_ON;
          q_next.st  = C_WAIT;
        end
      end
      C_ON: begin
        q_next.cmd                         = CMD_MRS;
        q_next.ba                          = 2'h3;
        q_next.addr[`MR3_EN_BIT]           = 1'b1;
        q_next.addr[`MR3_PAGE_LSB +: 2]    = q_reg.page;
        q_next.addr[`MR3_FMT_LSB +: 2]     = q_reg.fmt;
        q_next.mpage                       = q_reg.page;
        q_next.on                          = 1'b1;
        q_next.tmr                         = 8'(`T_MRD_MOD_CK);
        q_next.ret                         = C_IDLE;
        q_next.st                          = C_WAIT;
      end
      C_RD: begin
        // A1:A0 and A2 stay zero; A12 set for on-the-fly bursts
        q_next.cmd              = CMD_RD;
        q_next.ba               = q_reg.loc;
        q_next.addr[`A_BC_BIT]  = q_reg.bl == `BL_OTF;
        q_next.loc              = q_reg.loc + 2'h1;
        inc                     = 1'b1;
        q_next.tmr = (q_reg.mpage == 2'h0) ? 8'(`T_CCD_S_CK) :
                     8'(`T_CCD_L_CK);
        q_next.rot = q_reg.rot - 2'h1;
        q_next.ret = (q_reg.rot == 2'h0) ? C_IDLE : C_RD;
        q_next.st  = C_WAIT;
      end
      C_DRAIN: begin
        // the last burst must be in before tMPRR starts
        if (q_reg.pend == 3'h0) begin
          q_next.tmr = 8'(`T_MPRR_CK);
          q_next.ret = C_OFF;
          q_next.st  = C_WAIT;
        end
      end
      C_OFF: begin
        q_next.cmd = CMD_MRS;
        q_next.ba  = 2'h3;
        q_next.on  = 1'b0;
        q_next.tmr = 8'(`T_MOD_CK);
        q_next.ret = C_IDLE;
        q_next.st  = C_WAIT;
      end
      C_WAIT: begin
        // leaving at two makes command spacing equal the count
        if (q_reg.tmr <= 8'h02) begin
          q_next.st = q_reg.ret;
        end else begin
          q_next.tmr = q_reg.tmr - 8'h01;
        end
      end
    endcase

    q_next.pend = q_reg.pend + {2'h0, inc} - {2'h0, dec};
    if (ref_set) begin
      q_next.refused = 1'b1;
    end
    if (rd_set) begin
      q_next.rdone = 1'b1;
    end

    // read data stands only in the cycle after the strobe
    q_next.rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == `REG_CFG) begin
        q_next.rdata[`CFG_PAGE_LSB +: 2] = q_reg.page;
        q_next.rdata[`CFG_FMT_LSB +: 2]  = q_reg.fmt;
        q_next.rdata[`CFG_BL_LSB +: 2]   = q_reg.bl;
        q_next.rdata[`CFG_DLL_BIT]       = q_reg.dll_en;
      end else if (reg_addr == `REG_STAT) begin
        q_next.rdata[`ST_BUSY]  = q_reg.st != C_IDLE;
        q_next.rdata[`ST_ON]    = q_reg.on;
        q_next.rdata[`ST_REF]   = q_reg.refused;
        q_next.rdata[`ST_RDONE] = q_reg.rdone;
      end else if (reg_addr == `REG_RDAT) begin
        q_next.rdata = q_reg.rword;
      end
    end
  end

  // single state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign reg_rdata = q_reg.rdata;
  assign link.cmd  = q_reg.cmd;
  assign link.ba   = q_reg.ba;
  assign link.bg   = q_reg.bg;
  assign link.addr = q_reg.addr;
endmodule

/* File: core/mpr_defines.svh */
// constants of the pattern-register link: fields, resets and timing
`ifndef MPR_DEFINES_SVH
`define MPR_DEFINES_SVH

// clock and conversion of least times into whole cycles
`define CLK_MHZ        100
`define NS2CK(ns)      ((((ns) * `CLK_MHZ) + 999) / 1000)
`define T_RP_NS        15
`define T_RFC_NS       260
`define T_RP_CK        `NS2CK(`T_RP_NS)
`define T_RFC_CK       `NS2CK(`T_RFC_NS)
// times given in clocks
`define T_MRD_CK       8
`define T_MOD_CK       24
`define T_MRD_MOD_CK   ((`T_MRD_CK > `T_MOD_CK) ? `T_MRD_CK : `T_MOD_CK)
`define T_MPRR_CK      1
`define T_WR_MPR_CK    24
`define T_CCD_S_CK     8
`define T_CCD_L_CK     10

// link address bus
`define ADDR_W         14
`define A_ORD_BIT      2
`define A_BC_BIT       12

// mode register fields
`define MR0_BL_LSB     0
`define MR0_CLL_BIT    2
`define MR0_CLH_LSB    4
`define MR1_AL_LSB     3
`define MR3_PAGE_LSB   0
`define MR3_EN_BIT     2
`define MR3_FMT_LSB    11
`define MR5_PL_LSB     0
`define CL_BASE        9
`define RL_DEPTH       56
`define BL_FIX8        2'h0
`define BL_OTF         2'h1
`define BL_FIX4        2'h2
`define FMT_PAR        2'h1
`define FMT_STAG       2'h2

// pattern location reset contents
`define PAT0_RST       8'h55
`define PAT1_RST       8'h33
`define PAT2_RST       8'h0F
`define PAT3_RST       8'h00

// controller register port
`define REG_CMD        4'h0
`define REG_CFG        4'h4
`define REG_STAT       4'h8
`define REG_RDAT       4'hC
`define CMD_OP_LSB     0
`define CMD_SEL_LSB    4
`define CMD_BG_BIT     6
`define CMD_VAL_LSB    16
`define CFG_PAGE_LSB   0
`define CFG_FMT_LSB    2
`define CFG_BL_LSB     4
`define CFG_DLL_BIT    6
`define ST_BUSY        0
`define ST_ON          1
`define ST_REF         2
`define ST_RDONE       3

`endif

/* File: core/mpr_pkg.sv */
// types shared by both ends of the pattern-register link
`include "mpr_defines.svh"
package mpr_pkg;

  typedef enum logic [2:0] {
    CMD_DES, CMD_MRS, CMD_RD, CMD_WR, CMD_REF, CMD_PREA, CMD_ACT
  } link_cmd_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_ENTER, OP_READ, OP_ROT, OP_WRITE, OP_EXIT, OP_REF, OP_MRS
  } op_t;

  typedef enum logic [2:0] {
    C_IDLE, C_DLL, C_ON, C_RD, C_DRAIN, C_OFF, C_WAIT
  } ctl_state_t;

  typedef struct packed {
    logic       v;
    logic [1:0] loc;
    logic       bc;
    logic       a2;
    logic       pz;
  } rd_tag_t;

  typedef struct packed {
    logic [3:0][7:0]             pat;
    logic [`ADDR_W-1:0]          mr0;
    logic [`ADDR_W-1:0]          mr1;
    logic [`ADDR_W-1:0]          mr3;
    logic [`ADDR_W-1:0]          mr5;
    rd_tag_t [`RL_DEPTH-1:0]     dl;
    rd_tag_t                     bt;
    logic [2:0]                  cnt;
    logic [15:0]                 dq;
    logic                        dqv;
  } dram_reg_t;

  typedef struct packed {
    ctl_state_t         st;
    ctl_state_t         ret;
    logic [7:0]         tmr;
    logic [1:0]         page;
    logic [1:0]         fmt;
    logic [1:0]         bl;
    logic               dll_en;
    logic [1:0]         mpage;
    logic               on;
    logic               refused;
    logic               rdone;
    logic [1:0]         loc;
    logic [1:0]         rot;
    logic [2:0]         pend;
    logic [2:0]         bcnt;
    logic [31:0]        cap;
    logic [31:0]        rword;
    logic [31:0]        rdata;
    link_cmd_t          cmd;
    logic [1:0]         ba;
    logic [1:0]         bg;
    logic [`ADDR_W-1:0] addr;
  } ctl_reg_t;

endpackage

/* File: core/mpr_link_if.sv */
// command/address and read data link between controller and dram
`timescale 1ns/10ps
`include "mpr_defines.svh"
interface mpr_link_if;
  import mpr_pkg::*;
  link_cmd_t          cmd;
  logic [1:0]         ba;
  logic [1:0]         bg;
  logic [`ADDR_W-1:0] addr;
  logic [15:0]        dq;
  logic               dq_valid;

  modport ctl (output cmd, ba, bg, addr, input dq, dq_valid);
  modport dram (input cmd, ba, bg, addr, output dq, dq_valid);
endinterface

/* File: core/mpr_dram_end.sv */
// dram end: mode registers, pattern locations and readout bursts
`timescale 1ns/10ps
`include "mpr_defines.svh"
module mpr_dram_end
  import mpr_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  mpr_link_if.dram  link,
  output logic      mpr_on
);
  dram_reg_t   s_reg;
  dram_reg_t   s_next;
  rd_tag_t     tag;
  rd_tag_t     tap;
  rd_tag_t     cur;
  logic [2:0]  beat;
  logic [2:0]  ui;
  logic [2:0]  lim;
  logic [5:0]  cl;
  logic [5:0]  al;
  logic [5:0]  pl;
  logic [5:0]  rl;
  logic [1:0]  fmt;
  logic [1:0]  page;
  logic        en;
  logic [15:0] lane_bits;

  // parity latency code to clocks; reserved codes mean off
  function automatic logic [5:0] par_lat(input logic [2:0] c);
    case (c)
      3'h1:    par_lat = 6'h04;
      3'h2:    par_lat = 6'h05;
      3'h3:    par_lat = 6'h06;
      3'h4:    par_lat = 6'h08;
      default: par_lat = 6'h00;
    endcase
  endfunction

  // mode fields and read latency
  assign en   = s_reg.mr3[`MR3_EN_BIT];
  assign page = s_reg.mr3[`MR3_PAGE_LSB +: 2];
  assign fmt  = s_reg.mr3[`MR3_FMT_LSB +: 2];
  assign cl   = 6'(`CL_BASE) + {2'h0, s_reg.mr0[`MR0_CLH_LSB +: 3],
                s_reg.mr0[`MR0_CLL_BIT]};
  assign al   = (s_reg.mr1[`MR1_AL_LSB +: 2] == 2'h1) ? cl - 6'h01 :
                (s_reg.mr1[`MR1_AL_LSB +: 2] == 2'h2) ? cl - 6'h02 :
                6'h00;
  assign pl   = par_lat(s_reg.mr5[`MR5_PL_LSB +: 3]);
  assign rl   = al + cl + pl;

  // the tap sits two stages short of rl: one for the data flop
  assign tap  = s_reg.dl[rl - 6'h02];
  // a fresh burst takes over at once, cutting off any old one still running
  assign cur  = tap.v ? tap : s_reg.bt;
  assign beat = tap.v ? 3'h0 : s_reg.cnt;
  assign ui   = {beat[2] ^ cur.a2, beat[1:0]};
  assign lim  = cur.bc ? 3'h3 : 3'h7;

  // per-lane pattern selection; upper lanes repeat lanes 0 to 7
  for (genvar k = 0; k < 16; k++) begin : g_lane
    localparam logic [1:0] ROT  = 2'(k % 4);
    localparam logic [2:0] PBIT = 3'(k % 8);
    assign lane_bits[k] = !cur.pz ? 1'b0 :
      (fmt == `FMT_PAR)  ? s_reg.pat[0][PBIT] :
      (fmt == `FMT_STAG) ? s_reg.pat[cur.loc + ROT][ui] :
      s_reg.pat[cur.loc][ui];
  end

  // next state of the whole end
  always_comb begin
    s_next = s_reg;
    tag    = '0;
    // mode register set; bank group bit 0 extends the index
    if (link.cmd == CMD_MRS) begin
      unique case ({link.bg[0], link.ba})
        3'h0:    s_next.mr0 = link.addr;
        3'h1:    s_next.mr1 = link.addr;
        3'h3:    s_next.mr3 = link.addr;
        3'h5:    s_next.mr5 = link.addr;
        default: ;
      endcase
    end
    // reads are redirected to the locations while enabled
    if (link.cmd == CMD_RD && en) begin
      tag.v   = 1'b1;
      tag.loc = link.ba;
      tag.bc  = s_reg.mr0[`MR0_BL_LSB +: 2] == `BL_FIX4;
      tag.a2  = link.addr[`A_ORD_BIT];
      tag.pz  = page == 2'h0;
    end
    s_next.dl = {s_reg.dl[`RL_DEPTH-2:0], tag};
    // page 0 write: address bits 7:0 become beats 0 to 7
    if (link.cmd == CMD_WR && en && page == 2'h0) begin
      s_next.pat[link.ba] = link.addr[7:0];
    end
    // burst output; chopped bursts stop after four beats
    s_next.dqv = cur.v;
    s_next.dq  = cur.v ? lane_bits : 16'h0000;
    s_next.bt  = cur;
    s_next.cnt = beat + 3'h1;
    if (!cur.v || beat == lim) begin
      s_next.bt.v = 1'b0;
    end
  end

  // only reset reloads the patterns
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg     <= '0;
      s_reg.pat <= {`PAT3_RST, `PAT2_RST, `PAT1_RST, `PAT0_RST};
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.dq       = s_reg.dq;
  assign link.dq_valid = s_reg.dqv;
  assign mpr_on        = en;
endmodule

/* File: tb/mpr_link_properties.sv */
// checker of the command and read data link between both ends
`timescale 1ns/10ps
`include "mpr_defines.svh"
module mpr_link_properties
  import mpr_pkg::*;
(
  input logic        clk,
  input logic        resetn,
  input link_cmd_t   cmd,
  input logic [1:0]  ba,
  input logic [1:0]  bg,
  input logic [13:0] addr,
  input logic [15:0] dq,
  input logic        dq_valid
);
  logic [7:0][13:0] mr_reg;
  logic [63:0]      hist_reg;
  logic [7:0]       quiet_reg;
  logic             on;
  logic             mr3_mrs;
  int               rl;

  // mode state as the dram end sees it
  assign on = mr_reg[3][`MR3_EN_BIT];
  assign mr3_mrs = cmd == CMD_MRS && {bg[0], ba} == 3'h3;

  // read latency from stored cas and parity settings
  always_comb begin
    rl = `CL_BASE + {mr_reg[0][6:4], mr_reg[0][2]};
    case (mr_reg[5][2:0])
      3'h1: rl = rl + 4;
      3'h2: rl = rl + 5;
      3'h3: rl = rl + 6;
      3'h4: rl = rl + 8;
      default: rl = rl;
    endcase
  end

  // history of reads and quiet time; bursts overlap, so a shift register
  // rather than one counter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mr_reg    <= '0;
      hist_reg  <= '0;
      quiet_reg <= 8'hFF;
    end else begin
      if (cmd == CMD_MRS)
        mr_reg[{bg[0], ba}] <= addr;
      hist_reg <= {hist_reg[62:0], cmd == CMD_RD && on};
      if (cmd == CMD_WR || mr3_mrs)
        quiet_reg <= 8'h01;
      else if (quiet_reg != 8'hFF)
        quiet_reg <= quiet_reg + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_rd_nibble_start: assert property (cmd == CMD_RD |-> addr[1:0] == 2'h0)
    else $error("read with low address bits set");
  a_rd_beat_order: assert property (cmd == CMD_RD |-> !addr[`A_ORD_BIT])
    else $error("read with burst order bit set");
  a_rd_otf_a12: assert property (cmd == CMD_RD &&
      mr_reg[0][1:0] == `BL_OTF |-> addr[`A_BC_BIT])
    else $error("on the fly read without A12 high");
  a_rd_spacing: assert property (cmd == CMD_RD |=>
      (cmd != CMD_RD) [*7])
    else $error("reads closer than the short spacing");
  a_burst_run: assert property (hist_reg[rl - 1] |-> dq_valid [*8])
    else $error("burst missing or short at read latency");
  a_burst_cause: assert property ($rose(dq_valid) |-> hist_reg[rl - 1])
    else $error("burst started without a read one latency back");
  a_upper_byte: assert property (dq_valid |-> dq[15:8] == dq[7:0])
    else $error("upper byte differs from lower byte");
  a_upper_nibble: assert property (dq_valid &&
      mr_reg[3][12:11] == `FMT_STAG |-> dq[7:4] == dq[3:0])
    else $error("upper nibble differs in staggered burst");
  a_write_page0: assert property (cmd == CMD_WR |->
      on && mr_reg[3][1:0] == 2'h0)
    else $error("pattern write outside page 0 mode");
  a_cmd_quiet: assert property (cmd != CMD_DES |->
      quiet_reg >= `T_MOD_CK)
    else $error("command too soon after write or mode change");
  a_entry_prea: assert property (mr3_mrs && !on && addr[2] |->
      $past(cmd, 2) == CMD_PREA)
    else $error("entry without precharge two cycles before");
  a_exit_drained: assert property (mr3_mrs && on && !addr[2] |->
      !dq_valid && !$past(dq_valid))
    else $error("exit while read data still flowing");
endmodule

/* File: tb/testbench.sv */
// self-checking bench joining both link ends through the register port
`timescale 1ns/10ps
`include "mpr_defines.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); \
  end end
module testbench;
  logic        clk;
  logic        resetn;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        dll_locked;
  logic        mpr_on;
  int          fail_count;
  int          num_checks;
  logic [7:0]  pat [4];
  logic [31:0] d;

  mpr_link_if link ();
  mpr_ctl_end u_mpr_ctl_end (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dll_locked(dll_locked),
    .link(link));
  mpr_dram_end u_mpr_dram_end (.clk(clk), .resetn(resetn), .link(link),
    .mpr_on(mpr_on));
  mpr_link_properties u_mpr_link_properties (.clk(clk),
    .resetn(resetn), .cmd(link.cmd), .ba(link.ba),
    .bg(link.bg), .addr(link.addr), .dq(link.dq),
    .dq_valid(link.dq_valid));

  // clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up();
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one-cycle strobes; read data taken in the cycle after the strobe
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // bounded poll of one status bit; a hang ends the run
  task automatic wait_bit(input int b, input logic v);
    logic [31:0] s;
    for (int i = 0; i < 200; i++) begin
      rd(`REG_STAT, s);
      if (s[b] === v)
        return;
    end
    fail_count++;
    wrap_up();
  endtask

  task automatic op(input logic [2:0] o, input logic [1:0] s,
                    input logic b, input logic [13:0] v);
    wait_bit(`ST_BUSY, 1'b0);
    wr(`REG_CMD, {2'h0, v, 9'h0, b, s, 1'b0, o});
    wait_bit(`ST_BUSY, 1'b0);
  endtask

  task automatic cfg(input logic [1:0] pg, input logic [1:0] f,
                     input logic [1:0] bl);
    wr(`REG_CFG, {25'h0, 1'b1, bl, f, pg});
  endtask

  // read or rotate, then compare the captured lanes
  task automatic rd_loc(input logic [2:0] o, input logic [1:0] n,
                        input logic [31:0] e);
    op(o, n, 1'b0, 14'h0);
    wait_bit(`ST_RDONE, 1'b1);
    // a rotation sets read done at its first burst; let the rest land
    repeat (32) @(posedge clk);
    rd(`REG_RDAT, d);
    `CHK(d, e)
    wr(`REG_STAT, 32'h8);
  endtask

  // byte k of the capture is lane k, bit j is beat j
  function automatic logic [31:0] exp_rd(input logic [1:0] f,
                                         input logic [1:0] n);
    logic [31:0] r;
    for (int k = 0; k < 4; k++)
      case (f)
        `FMT_PAR:  r[k*8 +: 8] = {8{pat[0][k]}};
        `FMT_STAG: r[k*8 +: 8] = pat[2'(n + k)];
        default:   r[k*8 +: 8] = pat[n];
      endcase
    return r;
  endfunction

  initial begin
    resetn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    dll_locked = 1'b0;
    fail_count = 0;
    num_checks = 0;
    pat = '{`PAT0_RST, `PAT1_RST, `PAT2_RST, `PAT3_RST};
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    // defaults, unmapped place and write-only command register
    rd(`REG_STAT, d);
    `CHK(d, 32'h0)
    wr(4'h2, 32'hFFFFFFFF);
    rd(4'h2, d);
    `CHK(d, 32'h0)
    rd(`REG_CMD, d);
    `CHK(d, 32'h0)
    // read refused while the mode is off
    op(3'h2, 2'h0, 1'b0, 14'h0);
    rd(`REG_STAT, d);
    `CHK(d, 32'h4)
    wr(`REG_STAT, 32'h4);
    // entry holds off until the dll reports lock
    cfg(2'h0, `FMT_STAG, `BL_FIX8);
    rd(`REG_CFG, d);
    `CHK(d, {25'h0, 1'b1, `BL_FIX8, `FMT_STAG, 2'h0})
    wr(`REG_CMD, 32'h1);
    repeat (20) @(posedge clk);
    `CHK(mpr_on, 1'b0)
    dll_locked <= 1'b1;
    wait_bit(`ST_BUSY, 1'b0);
    `CHK(mpr_on, 1'b1)
    for (int n = 0; n < 4; n++)
      rd_loc(3'h2, 2'(n), exp_rd(`FMT_STAG, 2'(n)));
    // new patterns, bank-group bit set to show it is ignored
    for (int n = 0; n < 4; n++) begin
      pat[n] = 8'(8'hC3 + n * 8'h15);
      op(3'h4, 2'(n), 1'b1, {6'h0, pat[n]});
    end
    for (int n = 0; n < 4; n++)
      rd_loc(3'h2, 2'(n), exp_rd(`FMT_STAG, 2'(n)));
    rd_loc(3'h3, 2'h1, exp_rd(`FMT_STAG, 2'h0));
    // parity latency and on-the-fly burst mode
    op(3'h7, 2'h1, 1'b1, 14'h1);
    op(3'h7, 2'h0, 1'b0, 14'h1);
    cfg(2'h0, `FMT_STAG, `BL_OTF);
    rd_loc(3'h2, 2'h2, exp_rd(`FMT_STAG, 2'h2));
    op(3'h6, 2'h0, 1'b0, 14'h0);
    rd(`REG_STAT, d);
    `CHK(d, 32'h2)
    op(3'h1, 2'h0, 1'b0, 14'h0);
    rd(`REG_STAT, d);
    `CHK(d, 32'h6)
    wr(`REG_STAT, 32'h4);
    // every readout format, one entry and exit each
    for (int f = 0; f < 4; f++) begin
      op(3'h5, 2'h0, 1'b0, 14'h0);
      `CHK(mpr_on, 1'b0)
      cfg(2'h0, 2'(f), `BL_OTF);
      op(3'h1, 2'h0, 1'b0, 14'h0);
      rd_loc(3'h2, 2'h0, exp_rd(2'(f), 2'h0));
    end
    // page 1: writes refused, reads give zero data
    op(3'h5, 2'h0, 1'b0, 14'h0);
    cfg(2'h1, `FMT_STAG, `BL_OTF);
    op(3'h1, 2'h0, 1'b0, 14'h0);
    op(3'h4, 2'h0, 1'b0, 14'h0);
    rd(`REG_STAT, d);
    `CHK(d, 32'h6)
    wr(`REG_STAT, 32'h4);
    rd_loc(3'h2, 2'h1, 32'h0);
    // reset in mid-run restores the default patterns
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    pat = '{`PAT0_RST, `PAT1_RST, `PAT2_RST, `PAT3_RST};
    cfg(2'h0, `FMT_STAG, `BL_FIX8);
    op(3'h1, 2'h0, 1'b0, 14'h0);
    rd_loc(3'h2, 2'h3, exp_rd(`FMT_STAG, 2'h3));
    wrap_up();
  end
endmodule
